// [src/ppp_io_ports.sv]
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// - plain direction bit one drives pin out
// - plain direction register write-only, reads undefined
// - plain direction clears on reset, standby
// - plain latch readable, holds outputs, clears
// - wide direction register write-only, reads undefined
// - wide direction clears on reset, standby
// - modes four-six make wide port data bus
// - mode seven wide direction selects pin direction
// - wide latch, pin read-only, pullup reset zero
module ppp_io_ports
  import ppp_pkg::*;
(
  input  wire  logic                  clk,
  input  wire  logic                  reset_n,
  input  wire  logic                  hw_standby_n,
  input  wire  logic [2:0]            op_mode,
  input  wire  logic                  awvalid,
  output logic                        awready,
  input  wire  logic [PPP_ADDR_W-1:0] awaddr,
  input  wire  logic                  wvalid,
  output logic                        wready,
  input  wire  logic [31:0]           wdata,
  input  wire  logic [3:0]            wstrb,
  output logic                        bvalid,
  input  wire  logic                  bready,
  output logic [1:0]                  bresp,
  input  wire  logic                  arvalid,
  output logic                        arready,
  input  wire  logic [PPP_ADDR_W-1:0] araddr,
  output logic                        rvalid,
  input  wire  logic                  rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  input  wire  logic [7:0]            plain_pin_in,
  output logic [7:0]                  plain_pin_out,
  output logic [7:0]                  plain_pin_oe,
  input  wire  logic [7:0]            wide_pin_in,
  output logic [7:0]                  wide_pin_out,
  output logic [7:0]                  wide_pin_oe,
  output logic [7:0]                  wide_pullup_en,
  output logic                        wide_bus_mode,
  input  wire  logic [7:0]            bus_data_out,
  input  wire  logic                  bus_data_oe,
  output logic [7:0]                  bus_data_in
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic [7:0] plain_s1_reg, plain_s2_reg, wide_s1_reg, wide_s2_reg;
  logic [1:0] stby_sync_reg;
  logic       clear_regs;

  // release reset through two flops so every flop leaves reset together
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // pins come from outside; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      plain_s1_reg  <= 8'h00;
      plain_s2_reg  <= 8'h00;
      wide_s1_reg   <= 8'h00;
      wide_s2_reg   <= 8'h00;
      stby_sync_reg <= 2'h0;
    end
    else
    begin
      plain_s1_reg  <= plain_pin_in;
      plain_s2_reg  <= plain_s1_reg;
      wide_s1_reg   <= wide_pin_in;
      wide_s2_reg   <= wide_s1_reg;
      stby_sync_reg <= {stby_sync_reg[0], ~hw_standby_n};
    end
  end
  // hardware standby clears; software standby has no input, so retained
  assign clear_regs = stby_sync_reg[1];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  ppp_port_cfg_type plain_reg, plain_next, wide_reg, wide_next;
  logic [7:0]  pullup_reg, pullup_next;
  logic        aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [15:0] aw_idx_reg, aw_idx_next;
  logic [7:0]  wd_reg, wd_next;
  logic        wb_reg, wb_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        do_write, do_read;
  logic [15:0] ar_idx;
  logic        bus_mode;
  logic        awready_reg, wready_reg, arready_reg;

  assign do_write = aw_got_reg && w_got_reg && !bvalid_reg;
  // only a real handshake takes a read, never a request before ready
  assign do_read  = arvalid && arready_reg;
  assign ar_idx   = araddr[PPP_ADDR_W-1:2];
  assign bus_mode = (op_mode >= PPP_MODE_BUS_LO) &&
                    (op_mode <= PPP_MODE_BUS_HI);

  // write path, address and data taken in either order
  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    aw_idx_next = aw_idx_reg;
    wd_next     = wd_reg;
    wb_next     = wb_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    plain_next  = plain_reg;
    wide_next   = wide_reg;
    pullup_next = pullup_reg;
    if (awvalid && awready_reg)
    begin
      aw_got_next = 1'b1;
      aw_idx_next = awaddr[PPP_ADDR_W-1:2];
    end
    if (wvalid && wready_reg)
    begin
      w_got_next = 1'b1;
      wd_next    = wdata[7:0];
      wb_next    = wstrb[0];
    end
    if (do_write)
    begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = PPP_RESP_OKAY;
      case (aw_idx_reg)
        PPP_IDX_PLAIN_DIR:   if (wb_reg) plain_next.dir = wd_reg;
        PPP_IDX_PLAIN_LATCH: if (wb_reg) plain_next.latch = wd_reg;
        PPP_IDX_WIDE_DIR:    if (wb_reg) wide_next.dir = wd_reg;
        PPP_IDX_WIDE_LATCH:  if (wb_reg) wide_next.latch = wd_reg;
        PPP_IDX_WIDE_PULLUP: if (wb_reg) pullup_next = wd_reg;
        PPP_IDX_WIDE_PINS:   ; // read-only, write ignored
        default:             bresp_next = PPP_RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && bready)
      bvalid_next = 1'b0;
    if (clear_regs)
    begin
      plain_next  = '{dir: PPP_RESET_VALUE, latch: PPP_RESET_VALUE};
      wide_next   = '{dir: PPP_RESET_VALUE, latch: PPP_RESET_VALUE};
      pullup_next = PPP_RESET_VALUE;
    end
  end

  // read path, answer one cycle after the address is taken
  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (do_read)
    begin
      rvalid_next = 1'b1;
      rresp_next  = PPP_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      case (ar_idx)
        PPP_IDX_PLAIN_DIR:   rdata_next[7:0] = PPP_UNDEF_READ;
        PPP_IDX_WIDE_DIR:    rdata_next[7:0] = PPP_UNDEF_READ;
        PPP_IDX_PLAIN_LATCH: rdata_next[7:0] = plain_reg.latch;
        PPP_IDX_WIDE_LATCH:  rdata_next[7:0] = wide_reg.latch;
        PPP_IDX_WIDE_PULLUP: rdata_next[7:0] = pullup_reg;
        PPP_IDX_WIDE_PINS:   rdata_next[7:0] = wide_s2_reg;
        default:             rresp_next = PPP_RESP_SLVERR;
      endcase
    end
    else if (rvalid_reg && rready)
      rvalid_next = 1'b0;
  end

  // register state; all clears to the documented zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      aw_idx_reg <= 16'h0000;
      wd_reg     <= 8'h00;
      wb_reg     <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h0000_0000;
      plain_reg  <= '{dir: PPP_RESET_VALUE, latch: PPP_RESET_VALUE};
      wide_reg   <= '{dir: PPP_RESET_VALUE, latch: PPP_RESET_VALUE};
      pullup_reg <= PPP_RESET_VALUE;
    end
    else
    begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      aw_idx_reg <= aw_idx_next;
      wd_reg     <= wd_next;
      wb_reg     <= wb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      plain_reg  <= plain_next;
      wide_reg   <= wide_next;
      pullup_reg <= pullup_next;
    end
  end

  // ready flags are flops too: high while the slot is free
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      arready_reg <= 1'b0;
    end
    else
    begin
      awready_reg <= !aw_got_next && !(awvalid && awready_reg);
      wready_reg  <= !w_got_next && !(wvalid && wready_reg);
      arready_reg <= !rvalid_next && !(arvalid && arready_reg);
    end
  end

  // ----------------------------------------------------------------
  // pin drive, registered so outputs come from flops
  // ----------------------------------------------------------------
  logic [7:0] p_out_reg, p_oe_reg, w_out_reg, w_oe_reg, bus_in_reg;
  logic       mode_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p_out_reg  <= 8'h00;
      p_oe_reg   <= 8'h00;
      w_out_reg  <= 8'h00;
      w_oe_reg   <= 8'h00;
      bus_in_reg <= 8'h00;
      mode_reg   <= 1'b0;
    end
    else
    begin
      p_out_reg <= plain_next.latch;
      p_oe_reg  <= plain_next.dir;
      mode_reg  <= bus_mode;
      bus_in_reg <= wide_s2_reg;
      if (bus_mode)
      begin
        // direction bits ignored; the bus controller owns the pins
        w_out_reg <= bus_data_out;
        w_oe_reg  <= {8{bus_data_oe}};
      end
      else
      begin
        // only mode seven is legal here; others act as single-chip
        w_out_reg <= wide_next.latch;
        w_oe_reg  <= wide_next.dir;
      end
    end
  end

  assign plain_pin_out  = p_out_reg;
  assign plain_pin_oe   = p_oe_reg;
  assign wide_pin_out   = w_out_reg;
  assign wide_pin_oe    = w_oe_reg;
  assign wide_pullup_en = pullup_reg;
  assign wide_bus_mode  = mode_reg;
  assign bus_data_in    = bus_in_reg;
  assign awready        = awready_reg;
  assign wready         = wready_reg;
  assign arready        = arready_reg;
  assign bvalid         = bvalid_reg;
  assign bresp          = bresp_reg;
  assign rvalid         = rvalid_reg;
  assign rdata          = rdata_reg;
  assign rresp          = rresp_reg;

endmodule : ppp_io_ports

// [src/ppp_pkg.sv]
package ppp_pkg;

  // ------------------------------------------------------------------
  // register map (printed offsets are not all multiples of four, so
  // they are kept as indices; byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [15:0] PPP_IDX_WIDE_DIR    = 16'hFEBC;
  localparam logic [15:0] PPP_IDX_WIDE_PINS   = 16'hFF5C;
  localparam logic [15:0] PPP_IDX_WIDE_LATCH  = 16'hFF6C;
  localparam logic [15:0] PPP_IDX_WIDE_PULLUP = 16'hFF73;
  localparam logic [15:0] PPP_IDX_PLAIN_DIR   = 16'hFF40;
  localparam logic [15:0] PPP_IDX_PLAIN_LATCH = 16'hFF41;

  // ------------------------------------------------------------------
  // reset values and fixed answers
  // ------------------------------------------------------------------
  localparam logic [7:0]  PPP_RESET_VALUE     = 8'h00;
  localparam logic [7:0]  PPP_UNDEF_READ      = 8'hFF;
  localparam logic [1:0]  PPP_RESP_OKAY       = 2'h0;
  localparam logic [1:0]  PPP_RESP_SLVERR     = 2'h2;
  localparam int          PPP_ADDR_W          = 18;

  // operating mode encodings on the mode input
  localparam logic [2:0]  PPP_MODE_BUS_LO     = 3'h4;
  localparam logic [2:0]  PPP_MODE_BUS_HI     = 3'h6;
  localparam logic [2:0]  PPP_MODE_SINGLE     = 3'h7;

  // port configuration carried together
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] latch;
  } ppp_port_cfg_type;

endpackage : ppp_pkg

// [test/ppp_io_ports_properties.sv]
`timescale 1ns/10ps
// ----------------------------------------
// port-level checks of the io port pair
// ----------------------------------------
module ppp_io_ports_chk
  import ppp_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  hw_standby_n,
  input wire logic [2:0]            op_mode,
  input wire logic                  awvalid,
  input wire logic                  awready,
  input wire logic [PPP_ADDR_W-1:0] awaddr,
  input wire logic                  wvalid,
  input wire logic                  wready,
  input wire logic [31:0]           wdata,
  input wire logic [3:0]            wstrb,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [PPP_ADDR_W-1:0] araddr,
  input wire logic                  rvalid,
  input wire logic [31:0]           rdata,
  input wire logic [7:0]            plain_pin_oe,
  input wire logic [7:0]            plain_pin_out,
  input wire logic [7:0]            wide_pin_in,
  input wire logic [7:0]            wide_pin_oe,
  input wire logic [7:0]            wide_pullup_en,
  input wire logic                  wide_bus_mode,
  input wire logic                  bus_data_oe,
  input wire logic [7:0]            bus_data_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic       aw_go;
  logic       in_bus;
  logic [7:0] wd_reg;
  logic [1:0] up_cnt;
  // internal reset lags reset_n two edges, the pin path to bus_data_in three more
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      up_cnt <= 2'h0;
    else if (up_cnt != 2'h3)
      up_cnt <= up_cnt + 2'h1;
  // writes are checked only when both halves land on one edge
  assign aw_go  = awvalid && awready && wvalid && wready && wstrb[0];
  assign in_bus = op_mode >= PPP_MODE_BUS_LO && op_mode <= PPP_MODE_BUS_HI;
  // last accepted write byte, the reference for pin updates
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      wd_reg <= 8'h00;
    else if (aw_go)
      wd_reg <= wdata[7:0];
  a_plain_dir_write: assert property (
    aw_go && hw_standby_n && awaddr[17:2] == PPP_IDX_PLAIN_DIR
    |-> ##[1:2] plain_pin_oe == wd_reg) else $error("plain oe not updated");
  a_plain_latch_out: assert property (
    aw_go && hw_standby_n && awaddr[17:2] == PPP_IDX_PLAIN_LATCH
    |-> ##[1:2] plain_pin_out == wd_reg) else $error("plain out wrong");
  a_plain_dir_undef: assert property (
    arvalid && arready && araddr[17:2] == PPP_IDX_PLAIN_DIR
    |=> rvalid && rdata == {24'h000000, PPP_UNDEF_READ})
    else $error("plain dir read wrong");
  a_wide_dir_undef: assert property (
    arvalid && arready && araddr[17:2] == PPP_IDX_WIDE_DIR
    |=> rvalid && rdata == {24'h000000, PPP_UNDEF_READ})
    else $error("wide dir read wrong");
  a_bus_mode_oe: assert property (
    (in_bus && $stable(bus_data_oe))[*5]
    |-> wide_bus_mode && wide_pin_oe == {8{bus_data_oe}})
    else $error("bus mode drive wrong");
  a_bus_data_in: assert property (
    (up_cnt == 2'h3 && $stable(wide_pin_in))[*6]
    |-> bus_data_in == wide_pin_in)
    else $error("bus input not pin level");
  a_standby_dir: assert property (
    (!hw_standby_n)[*6] |-> plain_pin_oe == 8'h00)
    else $error("plain dir kept in standby");
  a_standby_latch: assert property (
    (!hw_standby_n)[*6] |-> plain_pin_out == 8'h00)
    else $error("plain latch kept in standby");
  a_standby_pullup: assert property (
    (!hw_standby_n)[*6] |-> wide_pullup_en == 8'h00)
    else $error("pullup kept in standby");
endmodule : ppp_io_ports_chk

bind ppp_io_ports ppp_io_ports_chk u_chk (.clk(clk), .reset_n(reset_n),
  .hw_standby_n(hw_standby_n), .op_mode(op_mode), .awvalid(awvalid),
  .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
  .wdata(wdata), .wstrb(wstrb), .arvalid(arvalid), .arready(arready),
  .araddr(araddr), .rvalid(rvalid), .rdata(rdata),
  .plain_pin_oe(plain_pin_oe), .plain_pin_out(plain_pin_out),
  .wide_pin_in(wide_pin_in), .wide_pin_oe(wide_pin_oe),
  .wide_pullup_en(wide_pullup_en), .wide_bus_mode(wide_bus_mode),
  .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in));

// [test/ppp_pin_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// pins and the device beyond them
// ----------------------------------------
module ppp_pin_model (
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext,
  output logic     [7:0] level
);
  // released bits follow the pull-up, else the far device's value
  assign level = (pin_oe & pin_out) | (~pin_oe & (pull_en | ext));
endmodule : ppp_pin_model

// [test/testbench.sv]
`timescale 1ns/10ps
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module testbench
  import ppp_pkg::*;
;
  logic clk, reset_n, hw_standby_n, bus_data_oe, wide_bus_mode;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [2:0] op_mode;
  logic [3:0] wstrb;
  logic [PPP_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] plain_pin_in, plain_pin_out, plain_pin_oe, wide_pin_in;
  logic [7:0] wide_pin_out, wide_pin_oe, wide_pullup_en, bus_data_out;
  logic [7:0] bus_data_in, ext_lvl, pd, pl, wd, wl, pu;
  int errors, checks;

  ppp_io_ports u_dut (.clk(clk), .reset_n(reset_n),
    .hw_standby_n(hw_standby_n), .op_mode(op_mode), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .plain_pin_in(plain_pin_in), .plain_pin_out(plain_pin_out),
    .plain_pin_oe(plain_pin_oe), .wide_pin_in(wide_pin_in),
    .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
    .wide_pullup_en(wide_pullup_en), .wide_bus_mode(wide_bus_mode),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .bus_data_in(bus_data_in));
  ppp_pin_model u_wide (.pin_oe(wide_pin_oe), .pin_out(wide_pin_out),
    .pull_en(wide_pullup_en), .ext(ext_lvl), .level(wide_pin_in));
  ppp_pin_model u_plain (.pin_oe(plain_pin_oe), .pin_out(plain_pin_out),
    .pull_en(8'h00), .ext(~ext_lvl), .level(plain_pin_in));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // bounded wait for a handshake sampled at a rising edge
  task automatic hs(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s !== 1'b1 && n < 64);
    if (s !== 1'b1)
    begin
      errors++;
      end_sim();
    end
  endtask : hs

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr  <= {idx, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // each half is released at the edge that takes it
    do
    begin
      @(posedge clk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 64);
    bready <= 1'b0;
    rs = bresp;
    if (bvalid !== 1'b1)
    begin
      errors++;
      end_sim();
    end
  endtask : wr

  task automatic rdr(input logic [15:0] idx);
    @(posedge clk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    hs(arready);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    hs(rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : rdr

  // level the pin register should show
  function automatic logic [7:0] lvl(input logic [7:0] oe, o, p, e);
    return (oe & o) | (~oe & (p | e));
  endfunction : lvl

  // no run may hang past the budget
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, bus_data_out, bus_data_oe} = '0;
    {errors, checks} = '0;
    hw_standby_n = 1'b1;
    op_mode = PPP_MODE_SINGLE;
    wstrb = 4'hF;
    ext_lvl = 8'hA5;
    void'($urandom(76));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(PPP_IDX_PLAIN_DIR);
    chk("plain dir", rd, 32'h000000FF);
    rdr(PPP_IDX_WIDE_DIR);
    chk("wide dir", rd, 32'h000000FF);
    rdr(PPP_IDX_PLAIN_LATCH);
    chk("plain latch rst", rd, 32'h00000000);
    rdr(PPP_IDX_WIDE_PULLUP);
    chk("pullup rst", rd, 32'h00000000);
    rdr(16'h0000);
    chk("unmapped", 32'(rs), 32'(PPP_RESP_SLVERR));
    chk("plain oe rst", 32'(plain_pin_oe), 32'h0);
    repeat (6)
    begin
      {pd, pl, wd, wl} = $urandom;
      pu = 8'($urandom);
      ext_lvl <= 8'($urandom);
      wr(PPP_IDX_PLAIN_DIR, pd);
      wr(PPP_IDX_PLAIN_LATCH, pl);
      wr(PPP_IDX_WIDE_DIR, wd);
      wr(PPP_IDX_WIDE_LATCH, wl);
      wr(PPP_IDX_WIDE_PULLUP, pu);
      wr(PPP_IDX_WIDE_PINS, ~pu);
      chk("pin wr resp", 32'(rs), 32'(PPP_RESP_OKAY));
      repeat (4) @(posedge clk);
      chk("pullup pins", 32'(wide_pullup_en), 32'(pu));
      chk("plain oe", 32'(plain_pin_oe), 32'(pd));
      chk("plain out", 32'(plain_pin_out), 32'(pl));
      chk("wide oe", 32'(wide_pin_oe), 32'(wd));
      chk("wide out", 32'(wide_pin_out), 32'(wl));
      rdr(PPP_IDX_PLAIN_LATCH);
      chk("plain latch", rd, 32'(pl));
      rdr(PPP_IDX_WIDE_LATCH);
      chk("wide latch", rd, 32'(wl));
      rdr(PPP_IDX_WIDE_PULLUP);
      chk("pullup", rd, 32'(pu));
      rdr(PPP_IDX_WIDE_PINS);
      chk("pins", rd, 32'(lvl(wd, wl, pu, ext_lvl)));
    end
    for (int m = 4; m <= 6; m++)
    begin
      op_mode <= 3'(m);
      {bus_data_oe, bus_data_out} <= 9'($urandom);
      repeat (6) @(posedge clk);
      chk("bus oe", 32'(wide_pin_oe), 32'({8{bus_data_oe}}));
      chk("bus flag", 32'(wide_bus_mode), 32'h1);
      chk("bus out", 32'(wide_pin_out), 32'(bus_data_out));
      chk("bus in", 32'(bus_data_in),
        32'(lvl({8{bus_data_oe}}, bus_data_out, pu, ext_lvl)));
    end
    op_mode <= PPP_MODE_SINGLE;
    repeat (4) @(posedge clk);
    chk("mode7 oe", 32'(wide_pin_oe), 32'(wd));
    chk("mode7 flag", 32'(wide_bus_mode), 32'h0);
    hw_standby_n <= 1'b0;
    repeat (8) @(posedge clk);
    hw_standby_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("stby oe", 32'(plain_pin_oe), 32'h0);
    chk("stby wide oe", 32'(wide_pin_oe), 32'h0);
    rdr(PPP_IDX_PLAIN_LATCH);
    chk("stby latch", rd, 32'h00000000);
    end_sim();
  end
endmodule : testbench
